// *** tb/led_driver_serial_config_test.sv ***
// Self-checking bench for the LED driver serial front end
`timescale 1ns/10ps
module led_driver_serial_config_test;
  import ledsc_pkg::*;
  localparam logic [15:0] PAT_A = 16'ha5c3;
  localparam logic [15:0] PAT_B = 16'h3c01;
  localparam logic [31:0] SHIFT_AB = {PAT_A, PAT_B};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic link_clk, serial_data_in, latch_strobe_n, serial_data_out;
  logic [15:0] short_detect, sink_outputs;
  logic [7:0] brightness_scale;
  ledsc_cmd_t command_fields;
  int errors = 0;
  int check_count = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  ledsc_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .serial_data_in(serial_data_in), .latch_strobe_n(latch_strobe_n),
    .short_detect(short_detect), .serial_data_out(serial_data_out),
    .sink_outputs(sink_outputs), .command_fields(command_fields),
    .brightness_scale(brightness_scale)
  );

  ledsc_ctrl_model u_ctrl (
    .hclk(hclk), .link_clk(link_clk), .serial_data_in(serial_data_in),
    .latch_strobe_n(latch_strobe_n)
  );

  // 40 MHz bus clock
  initial hclk = 1'h0;
  always #12.5 hclk = ~hclk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Four-state compare, so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One word transfer; each phase is held until ready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
    // Deselect between transfers so the select qualifier is exercised
    hsel <= 1'h0;
  endtask : xfer

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(what, exp, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask : rdchk

  // Whole image frame; lit is what the sinks should then show
  task automatic frame(input logic [15:0] w, input logic [15:0] lit);
    u_ctrl.strobe(1'h0);
    u_ctrl.send_word(w, 16);
    u_ctrl.strobe(1'h1);
    rdchk("image", ADDR_IMAGE, {16'h0, w});
    chk("sinks", {16'h0, lit}, {16'h0, sink_outputs});
  endtask : frame

  // Command word after mode entry; prev is the field set in force before
  task automatic command(input logic [9:0] w, input logic [8:0] prev);
    u_ctrl.enter(4);
    xfer(1'h0, ADDR_CMD, 32'h0);
    chk("mode", 32'h1, {31'h0, rd[STAT_MODE_BIT]});
    for (int i = 9; i >= 0; i--) begin
      u_ctrl.send_bit(w[i]);
      if (i < 2) begin
        chk("cascade", {31'h0, i == 0 && w[9]}, {31'h0, serial_data_out});
      end
    end
    chk("held", {23'h0, prev}, {23'h0, command_fields});
    u_ctrl.strobe(1'h1);
    rdchk("cmd", ADDR_CMD, {22'h0, w[1], w[2], 1'h0, w[9:3]});
    chk("fields", {23'h0, w[9:1]}, {23'h0, command_fields});
    chk("scale", {25'h0, w[9:3]} + 32'h1, {24'h0, brightness_scale});
  endtask : command

  // Main sequence
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    short_detect = 16'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (4) @(posedge hclk);
    rdchk("ctrl", ADDR_CTRL, {30'h0, CTRL_RESET});
    rdchk("cmd", ADDR_CMD, 32'h140);
    chk("fields", 32'h102, {23'h0, command_fields});
    chk("scale", 32'h41, {24'h0, brightness_scale});
    xfer(1'h1, ADDR_IMAGE, 32'hffff);
    rdchk("image", ADDR_IMAGE, 32'h0);
    rdchk("unmapped", 8'h0c, 32'h0);
    // Second frame shifts through while the first one stays shown
    frame(PAT_A, PAT_A);
    u_ctrl.strobe(1'h0);
    for (int i = 15; i >= 0; i--) begin
      u_ctrl.send_bit(PAT_B[i]);
      chk("cascade", {31'h0, SHIFT_AB[15 + i]}, {31'h0, serial_data_out});
    end
    chk("sinks", {16'h0, PAT_A}, {16'h0, sink_outputs});
    u_ctrl.strobe(1'h1);
    chk("sinks", {16'h0, PAT_B}, {16'h0, sink_outputs});
    // Brightness, then sleep with a frame latched meanwhile, then wake
    command({7'h4b, 3'h0}, 9'h102);
    command({7'h7f, 3'h6}, {7'h4b, 2'h0});
    chk("sinks", 32'h0, {16'h0, sink_outputs});
    frame(16'h00ff, 16'h0000);
    command({7'h40, 3'h4}, {7'h7f, 2'h3});
    chk("sinks", 32'hff, {16'h0, sink_outputs});
    // Three rises before the strobe falls must leave image mode in force
    u_ctrl.enter(3);
    xfer(1'h0, ADDR_CMD, 32'h0);
    chk("mode", 32'h0, {31'h0, rd[STAT_MODE_BIT]});
    frame(16'h8001, 16'h8001);
    // Blanking, then short errors loaded at the strobe rise and shifted out
    xfer(1'h1, ADDR_CTRL, 32'h2);
    rdchk("ctrl", ADDR_CTRL, 32'h2);
    chk("sinks", 32'h0, {16'h0, sink_outputs});
    xfer(1'h1, ADDR_CTRL, 32'h3);
    short_detect <= 16'hff00;
    frame(16'h8001, 16'h8001);
    chk("error", 32'h1, {31'h0, serial_data_out});
    u_ctrl.strobe(1'h0);
    u_ctrl.send_bit(1'h1);
    chk("error", 32'h0, {31'h0, serial_data_out});
    wrap_up();
  end

  // Watchdog far beyond the roughly 1200 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    wrap_up();
  end
endmodule : led_driver_serial_config_test

// *** tb/ledsc_ctrl_model.sv ***
// Display controller model that drives the serial link pins
`timescale 1ns/10ps
module ledsc_ctrl_model (
  input wire logic hclk,
  output logic link_clk,
  output logic serial_data_in,
  output logic latch_strobe_n
);
  // Clock stands low between frames, strobe idles high
  initial begin
    link_clk = 1'h0;
    serial_data_in = 1'h0;
    latch_strobe_n = 1'h1;
  end

  // One 200 ns link period, data set 3 cycles ahead of the rise
  task automatic send_bit(input logic b);
    serial_data_in <= b;
    repeat (3) @(posedge hclk);
    link_clk <= 1'h1;
    repeat (4) @(posedge hclk);
    link_clk <= 1'h0;
    @(posedge hclk);
  endtask : send_bit

  // Words leave most significant bit first
  task automatic send_word(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(w[i]);
    end
  endtask : send_word

  // Strobe moves only after the last clock fell; data toggles so no stale bit lingers
  task automatic strobe(input logic lvl);
    latch_strobe_n <= lvl;
    serial_data_in <= ~serial_data_in;
    repeat (8) @(posedge hclk);
  endtask : strobe

  // Mode entry attempt: n clock rises with strobe high, then strobe falls
  task automatic enter(input int n);
    send_word(16'h0000, n);
    strobe(1'h0);
  endtask : enter
endmodule : ledsc_ctrl_model

// *** verilog/ledsc_edge.sv ***
// Edge finder on already synchronised levels
`timescale 1ns/10ps
module ledsc_edge #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_reg;

  // Previous level, reset to the idle level to avoid a false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= RESET_VAL;
    end else begin
      prev_reg <= level;
    end
  end

  // One-cycle pulses
  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule : ledsc_edge

// *** verilog/ledsc_pkg.sv ***
// Package: constants, types and reset values of the LED driver serial front end
package ledsc_pkg;

  localparam int unsigned CHANNELS = 16;
  localparam int unsigned IMAGE_LEN = 16;
  localparam int unsigned CMD_LEN = 10;
  localparam int unsigned BRIGHT_W = 7;
  localparam int unsigned SCALE_W = 8;
  localparam int unsigned LINK_SYNC_W = CHANNELS + 3;

  // Clock rises with strobe high that select the mode change
  localparam logic [2:0] ENTRY_CLOCKS = 3'h4;
  localparam logic [2:0] CNT_MAX = 3'h7;

  // Command word layout, first shifted bit ends at the top
  localparam int unsigned CMD_BRIGHT_LSB = 3;
  localparam int unsigned CMD_SHORT_BIT = 2;
  localparam int unsigned CMD_SLEEP_BIT = 1;
  localparam int unsigned CMD_UNUSED_BIT = 0;

  // Power-on values of the command fields
  localparam logic [6:0] BRIGHT_RESET = 7'h40;
  localparam logic SHORT_RESET = 1'h1;
  localparam logic SLEEP_RESET = 1'h0;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IMAGE = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_OE_BIT = 0;
  localparam int unsigned CTRL_REPORT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Command status register fields
  localparam int unsigned STAT_SHORT_BIT = 8;
  localparam int unsigned STAT_SLEEP_BIT = 9;
  localparam int unsigned STAT_MODE_BIT = 16;

  typedef enum logic {
    IMAGE_DATA_MODE,
    COMMAND_DATA_MODE
  } ledsc_mode_t;

  typedef struct packed {
    logic [6:0] global_brightness_code;
    logic short_level_select;
    logic sleep_select;
  } ledsc_cmd_t;

  typedef struct packed {
    ledsc_mode_t mode;
    logic [15:0] shift;
    logic [2:0] clk_cnt;
    logic [15:0] image;
    ledsc_cmd_t cmd;
    logic [15:0] sink;
    logic [7:0] scale;
    logic [1:0] ctrl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } ledsc_state_t;

  localparam ledsc_state_t STATE_RESET = '{
    mode: IMAGE_DATA_MODE,
    shift: 16'h0000,
    clk_cnt: 3'h0,
    image: 16'h0000,
    cmd: '{global_brightness_code: BRIGHT_RESET, short_level_select: SHORT_RESET,
           sleep_select: SLEEP_RESET},
    sink: 16'h0000,
    scale: 8'h41,
    ctrl: CTRL_RESET,
    wr_pend: 1'h0,
    wr_addr: 8'h00,
    rdata: 32'h0000_0000
  };

endpackage : ledsc_pkg

// *** verilog/ledsc_sync.sv ***
// Two flip-flop synchroniser for inputs from outside the bus clock domain
`timescale 1ns/10ps
module ledsc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule : ledsc_sync

// *** verilog/ledsc_top.sv ***
// Serial front end of a 16-channel LED sink driver with AHB-Lite status access
`timescale 1ns/10ps
module ledsc_top
  import ledsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic serial_data_in,
  input wire logic latch_strobe_n,
  input wire logic [15:0] short_detect,
  output logic serial_data_out,
  output logic [15:0] sink_outputs,
  output ledsc_cmd_t command_fields,
  output logic [7:0] brightness_scale
);

  ledsc_state_t s_reg;
  ledsc_state_t s_next;
  logic [LINK_SYNC_W-1:0] pins_raw;
  logic [LINK_SYNC_W-1:0] pins_s;
  logic [15:0] short_s;
  logic din_s;
  logic strobe_s;
  logic link_clk_s;
  logic [1:0] edge_rise;
  logic [1:0] edge_fall;
  logic clk_rise;
  logic strobe_rise;
  logic strobe_fall;
  logic addr_ok;
  logic [1:0] ctrl_view;
  logic [31:0] read_word;

  // All pins cross into the bus clock through two flip-flops
  assign pins_raw = {short_detect, serial_data_in, latch_strobe_n, link_clk};

  ledsc_sync #(
    .W(LINK_SYNC_W),
    .RESET_VAL({{(LINK_SYNC_W - 2){1'b0}}, 2'h2})
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign short_s = pins_s[LINK_SYNC_W-1:3];
  assign din_s = pins_s[2];
  assign strobe_s = pins_s[1];
  assign link_clk_s = pins_s[0];

  // Edges of link clock (bit 0) and strobe (bit 1); strobe idles high
  ledsc_edge #(
    .W(2),
    .RESET_VAL(2'h2)
  ) u_edge (
    .clk(hclk),
    .rst_n(hresetn),
    .level({strobe_s, link_clk_s}),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  assign clk_rise = edge_rise[0];
  assign strobe_rise = edge_rise[1];
  assign strobe_fall = edge_fall[1];

  // AHB-Lite address phase qualifier
  assign addr_ok = hsel & htrans[1] & hready;

  // A control register write still in its data phase is forwarded to a following read
  always_comb begin
    ctrl_view = s_reg.ctrl;
    if (s_reg.wr_pend && (s_reg.wr_addr == ADDR_CTRL)) begin
      ctrl_view = hwdata[1:0];
    end
  end

  // Read data mux; low byte of the address decodes, unmapped reads zero
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CTRL: begin
        read_word[1:0] = ctrl_view;
      end
      ADDR_IMAGE: begin
        read_word[15:0] = s_reg.image;
      end
      ADDR_CMD: begin
        read_word[6:0] = s_reg.cmd.global_brightness_code;
        read_word[STAT_SHORT_BIT] = s_reg.cmd.short_level_select;
        read_word[STAT_SLEEP_BIT] = s_reg.cmd.sleep_select;
        read_word[STAT_MODE_BIT] = (s_reg.mode == COMMAND_DATA_MODE);
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_next = s_reg;

    // Bus side: writes land in the data phase, read data registered early
    if (s_reg.wr_pend && (s_reg.wr_addr == ADDR_CTRL)) begin
      s_next.ctrl = hwdata[1:0];
    end
    s_next.wr_pend = addr_ok & hwrite;
    s_next.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      s_next.rdata = read_word;
    end

    // Shift on each link clock rise; full width, the mode picks the tap
    if (clk_rise) begin
      s_next.shift = {s_reg.shift[14:0], din_s};
      if (strobe_s && (s_reg.clk_cnt != CNT_MAX)) begin
        s_next.clk_cnt = s_reg.clk_cnt + 3'h1;
      end
    end

    // Strobe rise latches the word from before a coincident clock rise, which still shifts unless an error report loads
    if (strobe_rise) begin
      s_next.clk_cnt = 3'h0;
      if (s_reg.mode == IMAGE_DATA_MODE) begin
        s_next.image = s_reg.shift;
        if (s_reg.ctrl[CTRL_REPORT_BIT]) begin
          // Error bits for lit channels, shifted out by the next frame
          s_next.shift = short_s & s_reg.shift;
        end
      end else begin
        s_next.cmd.global_brightness_code =
          s_reg.shift[CMD_BRIGHT_LSB +: BRIGHT_W];
        s_next.cmd.short_level_select = s_reg.shift[CMD_SHORT_BIT];
        s_next.cmd.sleep_select = s_reg.shift[CMD_SLEEP_BIT];
        s_next.mode = IMAGE_DATA_MODE;
      end
    end

    // Mode entry at the strobe fall that ends exactly four clocks
    if (strobe_fall && (s_reg.mode == IMAGE_DATA_MODE) &&
        (s_reg.clk_cnt == ENTRY_CLOCKS)) begin
      s_next.mode = COMMAND_DATA_MODE;
    end

    // Sink drive; sleep and the software enable both blank it
    if (s_reg.cmd.sleep_select || !s_reg.ctrl[CTRL_OE_BIT]) begin
      s_next.sink = 16'h0000;
    end else begin
      s_next.sink = s_reg.image;
    end

    // Current ratio numerator over 128
    s_next.scale = {1'b0, s_reg.cmd.global_brightness_code} + 8'h01;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs; zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign sink_outputs = s_reg.sink;
  assign command_fields = s_reg.cmd;
  assign brightness_scale = s_reg.scale;

  // Cascade tap: bit 15 for image words, bit 9 for command words
  assign serial_data_out = (s_reg.mode == COMMAND_DATA_MODE) ?
                           s_reg.shift[CMD_LEN-1] : s_reg.shift[IMAGE_LEN-1];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Shift path on a clock rise with no strobe in the same cycle
  a_shift_sample: assert property (clk_rise && !strobe_rise |=>
    s_reg.shift == {$past(s_reg.shift[14:0]), $past(din_s)})
    else $error("shift register did not sample serial input");

  a_image_latch: assert property (strobe_rise && s_reg.mode == IMAGE_DATA_MODE |=>
    s_reg.image == $past(s_reg.shift))
    else $error("image latch missed strobe rise");

  a_latch_hold: assert property (!strobe_rise |=> $stable(s_reg.image))
    else $error("image latch changed without strobe rise");

  a_mode_entry: assert property (strobe_fall && s_reg.mode == IMAGE_DATA_MODE &&
    s_reg.clk_cnt == ENTRY_CLOCKS |=> s_reg.mode == COMMAND_DATA_MODE)
    else $error("command mode not entered after four clocks");

  a_no_entry: assert property (strobe_fall && s_reg.mode == IMAGE_DATA_MODE &&
    s_reg.clk_cnt != ENTRY_CLOCKS |=> s_reg.mode == IMAGE_DATA_MODE)
    else $error("command mode entered on wrong clock count");

  a_cmd_latch: assert property (strobe_rise && s_reg.mode == COMMAND_DATA_MODE |=>
    s_reg.mode == IMAGE_DATA_MODE &&
    s_reg.cmd.global_brightness_code == $past(s_reg.shift[9:3]) &&
    s_reg.cmd.short_level_select == $past(s_reg.shift[2]) &&
    s_reg.cmd.sleep_select == $past(s_reg.shift[1]))
    else $error("command word not latched");

  a_bright_hold: assert property (!(strobe_rise &&
    s_reg.mode == COMMAND_DATA_MODE) |=> $stable(s_reg.cmd))
    else $error("command fields changed without command latch");

  a_sleep_off: assert property (s_reg.cmd.sleep_select |=>
    sink_outputs == 16'h0000)
    else $error("outputs on during sleep");

  a_sink_follow: assert property (!s_reg.cmd.sleep_select &&
    s_reg.ctrl[CTRL_OE_BIT] |=> sink_outputs == $past(s_reg.image))
    else $error("sink outputs do not follow latched image");

  a_scale_calc: assert property ($stable(s_reg.cmd) [*2] |->
    brightness_scale == {1'b0, s_reg.cmd.global_brightness_code} + 8'h01)
    else $error("brightness scale wrong");

  a_dout_pass: assert property (clk_rise && !strobe_rise &&
    s_reg.mode == IMAGE_DATA_MODE |=> serial_data_out == $past(s_reg.shift[14]))
    else $error("serial output not cascading shift data");

  a_err_report: assert property (strobe_rise && s_reg.mode == IMAGE_DATA_MODE &&
    s_reg.ctrl[CTRL_REPORT_BIT] |=> s_reg.shift == $past(short_s & s_reg.shift))
    else $error("short error report not loaded");

  c_mode_entry: cover property (strobe_fall && s_reg.clk_cnt == ENTRY_CLOCKS &&
    s_reg.mode == IMAGE_DATA_MODE);
  c_cmd_latch: cover property (strobe_rise && s_reg.mode == COMMAND_DATA_MODE);
  c_report: cover property (strobe_rise && s_reg.ctrl[CTRL_REPORT_BIT] &&
    (short_s != 16'h0000));
  c_sleep: cover property ($rose(s_reg.cmd.sleep_select));

endmodule : ledsc_top
